// file: rtl/mix_check_defs.vh
`ifndef MIX_CHECK_DEFS_VH
`define MIX_CHECK_DEFS_VH
// ----------------------------------------
// command opcodes (decoded command byte)
// ----------------------------------------
`define OP_PLAY 8'h10
`define OP_FADR 8'h11
`define OP_SAFE 8'h20
`define OP_READ_ERROR_CMD 8'h21
`define OP_ERROR_CLEAR_CMD 8'h22
`define OP_STATUS_OUTPUT_SELECT_CMD 8'h23
`define OP_AUDCH 8'h30
`define OP_AUDCFG 8'h31
`define OP_STOP 8'h40
// ----------------------------------------
// error flag positions
// ----------------------------------------
`define ERR_CMD 0
`define ERR_MIX 1
`define ERR_W 2
// ----------------------------------------
// safety enable bits in byte 1
// ----------------------------------------
`define SAFE_CMD 0
`define SAFE_MIX 1
// ----------------------------------------
// frequency groups and algorithms
// ----------------------------------------
`define GRP_8K 3'h1
`define GRP_11K 3'h2
`define GRP_12K 3'h3
`define ALG_HQ 3'h1
// ----------------------------------------
// misc constants
// ----------------------------------------
`define MAX_MIX 3'h4
`define MIX_SAI_LIMITED 3'h3
`define CH_LAST 2'h3
`define PHR_UNIT 13'h0400
`define ZERO_FLAGS 2'h0
`endif

// file: rtl/cmd_copy_store.v
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// holds the first copy of a command in two-times mode
// ----------------------------------------
module cmd_copy_store #(
  parameter W = 32
) (
  input wire clk,
  input wire rst,
  input wire load,
  input wire [W-1:0] dataIn,
  output reg [W-1:0] dataOut
);
  always @(posedge clk) begin
    if (rst) begin
      dataOut <= {W{1'b0}};
    end else if (load) begin
      dataOut <= dataIn;
    end
  end
endmodule // cmd_copy_store
`default_nettype wire

// file: rtl/mixing_admission_and_command_check.v
`timescale 1ns/1ns
`default_nettype none
`include "mix_check_defs.vh"
// Contract
// [R01] four channels, each command acts alone
// [R02] no audio port: all four channels play
// [R03] port on 11k/12k groups: total three
// [R04] port on 8k group: total four
// [R05] no high-quality adpcm with port, 8k
// [R06] port uses one slot per side
// [R07] mixed channels share one frequency group
// [R08] foreign group phrase plays at selected rate
// [R09] port input enabled fixes output group
// [R10] enable detectors, read flags, clear flags
// [R11] select status pin a or b
// [R12] command check only when enabled
// [R13] phrase beyond count flags command error
// [R14] two-times mode: accept matching copies only
// [R15] copy mismatch flags error and discards
// [R16] command flag readable, cleared by clear
// [R17] host lowers volumes before clamping
// [R18] read command latches error state
// [R19] two-times mode read is two bytes
// [R20] flags sticky until clear command
// [R21] refused start flags mixing-number error
module mixing_admission_and_command_check #(
  parameter CHANNELS = 4
) (
  input wire clk,
  input wire rst,
  input wire cmdValid,
  input wire [7:0] cmdCode,
  input wire [7:0] cmdArg0,
  input wire [7:0] cmdArg1,
  input wire [7:0] cmdArg2,
  input wire twoTimesMode,
  input wire [1:0] phraseCountSel,
  input wire [3:0] chDone,
  output reg [3:0] chPlaying_q,
  output reg [2:0] outGroup_q,
  output reg [2:0] playGroup_q,
  output reg playStart_q,
  output reg [1:0] playCh_q,
  output reg [11:0] playPhrase_q,
  output reg cmdAccept_q,
  output reg [15:0] readData_q,
  output reg [1:0] readLen_q,
  output reg [7:0] safeEnable_q,
  output reg [1:0] errFlags_q,
  output reg statusPinA_q,
  output reg statusPinB_q
);
  // ----------------------------------------
  // functions
  // ----------------------------------------
  function [2:0] popCount;
    input [3:0] v;
    begin
      popCount = {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]};
    end
  endfunction

  function [1:0] portSlots;
    input leftEn;
    input rightEn;
    begin
      portSlots = {1'b0, leftEn} + {1'b0, rightEn};
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  localparam ST_FIRST = 2'b01;
  localparam ST_SECOND = 2'b10;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg leftInputEnable_q;
  reg rightInputEnable_q;
  reg [2:0] portGroup_q;
  reg statusSel_q;
  wire [31:0] copyWord;
  wire [31:0] firstCopy;
  reg copyLoad;
  reg execute;
  reg mismatch;

  assign copyWord = {cmdCode, cmdArg0, cmdArg1, cmdArg2};

  cmd_copy_store #(
    .W(32)
  ) firstCopyStore (
    .clk(clk),
    .rst(rst),
    .load(copyLoad),
    .dataIn(copyWord),
    .dataOut(firstCopy)
  );

  // ----------------------------------------
  // two-times sequencing
  // ----------------------------------------
  always @* begin
    state_d = state_q;
    copyLoad = 1'b0;
    execute = 1'b0;
    mismatch = 1'b0;
    case (state_q)
      ST_FIRST: begin
        if (cmdValid) begin
          if (twoTimesMode) begin
            copyLoad = 1'b1; // R14
            state_d = ST_SECOND;
          end else begin
            execute = 1'b1;
          end
        end
      end
      ST_SECOND: begin
        if (cmdValid) begin
          state_d = ST_FIRST;
          if (copyWord == firstCopy) begin
            execute = 1'b1; // R14
          end else begin
            mismatch = 1'b1; // R15
          end
        end
      end
      default: begin
        state_d = ST_FIRST;
      end
    endcase
  end

  // ----------------------------------------
  // admission checks
  // ----------------------------------------
  wire [1:0] chSel = cmdArg0[1:0];
  wire [11:0] phrase = {cmdArg1[3:0], cmdArg2};
  wire [12:0] phraseLimit = {11'h000, phraseCountSel} * `PHR_UNIT + `PHR_UNIT;
  wire phraseBad = ({1'b0, phrase} >= phraseLimit); // R13
  wire portOn = leftInputEnable_q | rightInputEnable_q;
  wire [2:0] mixTotal = (portOn && portGroup_q != `GRP_8K) ? `MIX_SAI_LIMITED : `MAX_MIX; // R03 R04 R02
  wire [3:0] active = chPlaying_q & ~chDone;
  wire [2:0] used = popCount(active) + {1'b0, portSlots(leftInputEnable_q, rightInputEnable_q)}; // R06
  wire chBusy = active[chSel]; // R01
  wire chForbidden = portOn && portGroup_q != `GRP_8K && chSel == `CH_LAST; // R03
  wire hqForbidden = portOn && portGroup_q == `GRP_8K && cmdArg1[6:4] == `ALG_HQ; // R05
  wire mixBad = chForbidden || hqForbidden || (!chBusy && (used >= mixTotal)); // R21
  wire [2:0] reqGroup = cmdArg0[6:4];
  wire isPlay = execute && cmdCode == `OP_PLAY;
  wire isFadr = execute && cmdCode == `OP_FADR;
  wire cmdErrSet = safeEnable_q[`SAFE_CMD] && (mismatch || ((isPlay || isFadr) && phraseBad)); // R12 R13 R15
  wire mixErrSet = safeEnable_q[`SAFE_MIX] && isPlay && !phraseBad && mixBad; // R21
  wire clearReq = execute && cmdCode == `OP_ERROR_CLEAR_CMD;
  wire [1:0] setVec = {mixErrSet, cmdErrSet};
  wire [1:0] flagsNext = (clearReq ? `ZERO_FLAGS : errFlags_q) | setVec; // R20 R16

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      state_q <= ST_FIRST;
      chPlaying_q <= 4'h0;
      outGroup_q <= 3'h0;
      playGroup_q <= 3'h0;
      playStart_q <= 1'b0;
      playCh_q <= 2'h0;
      playPhrase_q <= 12'h000;
      cmdAccept_q <= 1'b0;
      readData_q <= 16'h0000;
      readLen_q <= 2'h0;
      safeEnable_q <= 8'h00;
      errFlags_q <= 2'h0;
      statusPinA_q <= 1'b0;
      statusPinB_q <= 1'b0;
      leftInputEnable_q <= 1'b0;
      rightInputEnable_q <= 1'b0;
      portGroup_q <= 3'h0;
      statusSel_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cmdAccept_q <= execute;
      playStart_q <= 1'b0;
      // set wins over clear in the same cycle
      errFlags_q <= flagsNext; // R10 R20
      chPlaying_q <= active;
      // errors shown live so a clear drops the pin next cycle
      statusPinA_q <= !statusSel_q && (flagsNext != `ZERO_FLAGS); // R11
      statusPinB_q <= statusSel_q && (flagsNext != `ZERO_FLAGS); // R11
      if (portOn) begin
        outGroup_q <= portGroup_q; // R09
      end
      if (execute) begin
        case (cmdCode)
          `OP_PLAY: begin
            if (!phraseBad && !mixBad) begin
              chPlaying_q <= active | (4'h1 << chSel); // R01
              playStart_q <= 1'b1;
              playCh_q <= chSel;
              playPhrase_q <= phrase;
              // a foreign-group phrase still runs at the shared rate
              playGroup_q <= portOn ? portGroup_q : outGroup_q; // R07 R08
              if (!portOn && active == 4'h0) begin
                outGroup_q <= reqGroup; // R07
                playGroup_q <= reqGroup;
              end
            end
          end
          `OP_STOP: begin
            chPlaying_q <= active & ~(4'h1 << chSel); // R01
          end
          `OP_SAFE: begin
            safeEnable_q <= cmdArg0; // R10 R12
          end
          `OP_READ_ERROR_CMD: begin
            readData_q <= {6'h00, flagsNext, 6'h00, flagsNext}; // R18
            readLen_q <= twoTimesMode ? 2'h2 : 2'h1; // R19
          end
          `OP_STATUS_OUTPUT_SELECT_CMD: begin
            statusSel_q <= cmdArg0[0]; // R11
          end
          `OP_AUDCH: begin
            leftInputEnable_q <= cmdArg0[0]; // R06
            rightInputEnable_q <= cmdArg0[1]; // R06
          end
          `OP_AUDCFG: begin
            portGroup_q <= cmdArg0[2:0]; // R09
          end
          default: begin
            readLen_q <= readLen_q;
          end
        endcase
      end
    end
  end
endmodule // mixing_admission_and_command_check
`default_nettype wire

// file: bench/host_cmd_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// host command source
// ----
module host_cmd_model (
  input wire logic clk,
  input wire logic twoTimes,
  output logic cmdValid,
  output logic [7:0] cmdCode,
  output logic [7:0] cmdArg0,
  output logic [7:0] cmdArg1,
  output logic [7:0] cmdArg2
);
  initial {cmdValid, cmdCode, cmdArg0, cmdArg1, cmdArg2} = 33'h0;
  // no volume commands issued, so no clamped sum to lower
  // bad flips one data bit of the second copy
  task automatic send(input logic [7:0] c, x, y, z, input logic bad);
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdCode <= c;
    cmdArg0 <= x;
    cmdArg1 <= y;
    cmdArg2 <= z;
    if (twoTimes) begin
      @(posedge clk);
      cmdArg2 <= z ^ {7'h0, bad};
    end
    @(posedge clk);
    cmdValid <= 1'b0;
    // released code and arg2 lines carry junk, never the old value; arg0 and arg1 keep it
    cmdCode <= ~c;
    cmdArg2 <= ~z;
  endtask
endmodule // host_cmd_model
`default_nettype wire

// file: bench/mix_check_monitor.sv
`timescale 1ns/1ns
`default_nettype none
`include "mix_check_defs.vh"
// ----
// port checks
// ----
module mix_check_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmdValid,
  input wire logic [7:0] cmdCode,
  input wire logic twoTimesMode,
  input wire logic [1:0] phraseCountSel,
  input wire logic playStart_q,
  input wire logic [11:0] playPhrase_q,
  input wire logic cmdAccept_q,
  input wire logic [15:0] readData_q,
  input wire logic [1:0] readLen_q,
  input wire logic [7:0] safeEnable_q,
  input wire logic [1:0] errFlags_q,
  input wire logic statusPinA_q,
  input wire logic statusPinB_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  start_cause_a: assert property (playStart_q |-> $past(cmdValid) && $past(cmdCode) == `OP_PLAY)
    else $error("start without play");
  start_range_a: assert property (playStart_q |-> playPhrase_q[11:10] <= phraseCountSel)
    else $error("phrase out of range");
  flag_sticky_a: assert property (|($past(errFlags_q) & ~errFlags_q) |-> $past(cmdCode) == `OP_ERROR_CLEAR_CMD)
    else $error("flag dropped");
  cmd_gate_a: assert property ($rose(errFlags_q[0]) |-> $past(safeEnable_q[`SAFE_CMD]))
    else $error("command check off");
  mix_gate_a: assert property ($rose(errFlags_q[1]) |-> $past(safeEnable_q[`SAFE_MIX]))
    else $error("mix check off");
  read_len_a: assert property (cmdAccept_q && $past(cmdCode) == `OP_READ_ERROR_CMD
    |-> readLen_q == (twoTimesMode ? 2'h2 : 2'h1))
    else $error("read length");
  read_latch_a: assert property (cmdAccept_q && $past(cmdCode) == `OP_READ_ERROR_CMD |-> readData_q[1:0] == $past(errFlags_q))
    else $error("read data");
  pin_excl_a: assert property (!(statusPinA_q && statusPinB_q))
    else $error("both pins");
  cover property (playStart_q);
  cover property ($rose(errFlags_q[0]));
  cover property ($rose(errFlags_q[1]));
endmodule // mix_check_monitor
bind mixing_admission_and_command_check mix_check_monitor i_mon (.*);
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "mix_check_defs.vh"
// ----
// bench
// ----
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic twoTimesMode = 1'b0;
  logic [3:0] chDone = 4'h0;
  logic cmdValid, playStart_q, cmdAccept_q, statusPinA_q, statusPinB_q;
  logic [7:0] cmdCode, cmdArg0, cmdArg1, cmdArg2;
  logic [3:0] chPlaying_q;
  logic [2:0] outGroup_q;
  logic [15:0] readData_q;
  logic [1:0] readLen_q, errFlags_q, playCh_q;
  logic [1:0] phraseSel = 2'h0;
  logic [2:0] playGroup_q;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  // code, arg0, arg1, arg2, start nibble, flags nibble
  logic [39:0] rows [0:24] = '{40'h20_00_00_00_00, 40'h10_10_04_00_00, 40'h20_03_00_00_00, 40'h10_10_04_00_01,
    40'h22_00_00_00_00, 40'h10_10_03_ff_10, 40'h10_11_00_05_10, 40'h10_12_00_06_10, 40'h10_13_00_07_10,
    40'h40_13_00_00_00, 40'h40_12_00_00_00, 40'h40_11_00_00_00, 40'h31_02_00_00_00, 40'h30_03_00_00_00,
    40'h10_21_00_01_02, 40'h22_00_00_00_00, 40'h30_01_00_00_00, 40'h10_21_00_01_10, 40'h10_23_00_01_02,
    40'h22_00_00_00_00, 40'h31_01_00_00_00, 40'h10_12_10_01_02, 40'h22_00_00_00_00, 40'h10_13_00_01_10,
    40'h10_12_00_01_02};
  always #5 clk = ~clk;
  host_cmd_model i_host (.clk(clk), .twoTimes(twoTimesMode), .cmdValid(cmdValid), .cmdCode(cmdCode),
    .cmdArg0(cmdArg0), .cmdArg1(cmdArg1), .cmdArg2(cmdArg2));
  mixing_admission_and_command_check i_dut (.clk(clk), .rst(rst), .cmdValid(cmdValid), .cmdCode(cmdCode),
    .cmdArg0(cmdArg0), .cmdArg1(cmdArg1), .cmdArg2(cmdArg2), .twoTimesMode(twoTimesMode),
    .phraseCountSel(phraseSel), .chDone(chDone), .chPlaying_q(chPlaying_q), .outGroup_q(outGroup_q),
    .playGroup_q(playGroup_q), .playStart_q(playStart_q), .playCh_q(playCh_q), .playPhrase_q(),
    .cmdAccept_q(cmdAccept_q),
    .readData_q(readData_q), .readLen_q(readLen_q), .safeEnable_q(), .errFlags_q(errFlags_q),
    .statusPinA_q(statusPinA_q), .statusPinB_q(statusPinB_q));
  task chk(input logic [15:0] act, exp);
    checked++;
    if (act !== exp) begin
      failures++;
      $display("Error at %0t: got %h want %h", $time, act, exp);
    end
  endtask
  task cmd(input logic [7:0] c, x, input logic bad);
    i_host.send(c, x, 8'h0, 8'h1, bad);
    #1;
  endtask
  task end_of_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // hang guard, about ten times the expected run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      failures++;
      end_of_test;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 25; i++) begin
      i_host.send(rows[i][39:32], rows[i][31:24], rows[i][23:16], rows[i][15:8], 1'b0);
      #1;
      chk(playStart_q, rows[i][4]);
      chk(errFlags_q, rows[i][1:0]);
    end
    chk(outGroup_q, 16'h1);
    chk(chPlaying_q, 16'hb);
    chk(playCh_q, 16'h3);
    chk(playGroup_q, 16'h1);
    cmd(`OP_READ_ERROR_CMD, 8'h0, 1'b0);
    chk(readData_q[1:0], 16'h2);
    chk(readLen_q, 16'h1);
    $display("rows done");
    cmd(`OP_STATUS_OUTPUT_SELECT_CMD, 8'h1, 1'b0);
    repeat (2) @(posedge clk);
    #1 chk({statusPinA_q, statusPinB_q}, 16'h1);
    cmd(`OP_ERROR_CLEAR_CMD, 8'h0, 1'b0);
    @(posedge clk);
    chDone <= 4'hf;
    @(posedge clk);
    chDone <= 4'h0;
    repeat (2) @(posedge clk);
    #1 chk({chPlaying_q, errFlags_q, statusPinB_q}, 16'h0);
    $display("pins done");
    @(posedge clk);
    rst <= 1'b1;
    twoTimesMode <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    #1 chk(errFlags_q, 16'h0);
    cmd(`OP_SAFE, 8'h1, 1'b0);
    cmd(`OP_PLAY, 8'h10, 1'b1);
    chk({cmdAccept_q, playStart_q, errFlags_q}, 16'h1);
    cmd(`OP_READ_ERROR_CMD, 8'h0, 1'b0);
    chk(readData_q, 16'h0101);
    chk(readLen_q, 16'h2);
    cmd(`OP_ERROR_CLEAR_CMD, 8'h0, 1'b0);
    cmd(`OP_PLAY, 8'h10, 1'b0);
    chk({playStart_q, errFlags_q}, 16'h4);
    @(posedge clk);
    phraseSel <= 2'h1;
    i_host.send(`OP_PLAY, 8'h11, 8'h04, 8'h00, 1'b0);
    #1;
    chk({playStart_q, errFlags_q}, 16'h4);
    $display("two-times done");
    end_of_test;
  end
endmodule // testbench
`default_nettype wire
